// *** dv/cell_env_model.sv ***
// battery, thermistor and status-pin pull-ups outside the charger monitor
// assumes bench-set analog levels; output cap swings fully when no cell
module cell_env_model
    import charger_monitor_pkg::*;
(
    input  int                                thMv,
    input  logic                              batPresent,
    input  logic                              supplyOk,
    input  logic                              sdGrounded,
    input  logic                              junctionHot,
    input  logic                              currentLow,
    input  charger_monitor_pkg::chargeCtl_t   ctl,
    input  charger_monitor_pkg::statusPins_t  statusPins,
    output charger_monitor_pkg::senseIn_t     senseIn,
    output logic                              litA,
    output logic                              litB
);
    timeunit 1ns;
    timeprecision 1ns;
    import charger_monitor_pkg::*;
    int vout;
    // no cell: bare cap follows the probe current, rests below recharge
    always_comb begin
        if (batPresent) vout = 4150;
        else if (ctl.sourceDetect) vout = 4200;
        else if (ctl.sinkDetect) vout = 0;
        else vout = 3800;
    end
    assign senseIn = {!sdGrounded, !supplyOk, thMv > 900, thMv < 780,
                      thMv < 225, thMv > 248, junctionHot,
                      currentLow | !batPresent, vout < 3000, vout > 4050};
    // pull-up holds a released pin high, so a lit led means sinking
    assign litA = statusPins.aOeN ? 1'b0 : !statusPins.aOut;
    assign litB = statusPins.bOeN ? 1'b0 : !statusPins.bOut;
endmodule

// *** dv/charger_monitor_protection_bench.sv ***
// self-checking bench of the charger monitor
// assumes cell_env_model stands in for battery, thermistor and leds
module charger_monitor_protection_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import charger_monitor_pkg::*;
    localparam int DEG = 981;
    localparam int DET = 4;
    logic         sys_clk = 1'b0;
    logic         rst = 1'b1;
    logic         maxChargeExpired = 1'b0;
    logic         maxPrechargeExpired = 1'b0;
    regReq_t      regReq = '0;
    logic [7:0]   rdata;
    logic         irq;
    chargeCtl_t   ctl;
    statusPins_t  statusPins;
    senseIn_t     senseIn;
    int           thMv = 600; // half pull-up resistor sits mid-window
    logic         batPresent = 1'b1;
    logic         supplyOk = 1'b1;
    logic         sdGrounded = 1'b0;
    logic         junctionHot = 1'b0;
    logic         currentLow = 1'b0;
    logic         litA;
    logic         litB;
    int           bad_count = 0;
    int           checks_done = 0;
    int           sinkCyc = 0;
    int           srcCyc = 0;
    int           n;
    int           s0;
    int           c0;
    logic [7:0]   d;

    always #50 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        sinkCyc <= sinkCyc + int'(ctl.sinkDetect);
        srcCyc <= srcCyc + int'(ctl.sourceDetect);
    end

    // small time base keeps the deglitch near a thousand cycles
    charger_monitor #(.MAX_CHARGE_CYCLES(216000)) charger_monitor_i (
        .sys_clk(sys_clk), .rst(rst), .senseIn(senseIn),
        .maxChargeExpired(maxChargeExpired),
        .maxPrechargeExpired(maxPrechargeExpired), .regReq(regReq),
        .rdata(rdata), .irq(irq), .ctl(ctl), .statusPins(statusPins));
    cell_env_model cell_env_model_i (
        .thMv(thMv), .batPresent(batPresent), .supplyOk(supplyOk),
        .sdGrounded(sdGrounded), .junctionHot(junctionHot),
        .currentLow(currentLow), .ctl(ctl), .statusPins(statusPins),
        .senseIn(senseIn), .litA(litA), .litB(litB));

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_lit(input logic [1:0] exp);
        checks_done++;
        if ({litA, litB} !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, {litA, litB}, exp);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask
    // waits for a led pattern, bounded; n returns the cycles spent
    task automatic wait_lit(input logic [1:0] exp);
        n = 0;
        while ({litA, litB} !== exp) begin
            tick(1);
            n++;
            if (n > 3000) begin
                chk_lit(exp);
                wrap_up();
            end
        end
        chk_lit(exp);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        regReq <= '{addr: a, wdata: v, write: 1'b1, read: 1'b0};
        @(posedge sys_clk);
        regReq.write <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge sys_clk);
        regReq <= '{addr: a, wdata: 8'h00, write: 1'b0, read: 1'b1};
        @(posedge sys_clk);
        regReq.read <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic sc_reset;
        tick(1);
        chk_lit(2'b00);
        chk(8'(ctl.refEnable), 8'h00);
        rd(4'hc);
        chk(d, 8'h01);
        rd(4'h8);
        chk(d, 8'h00);
        rd(4'h2);
        chk(d, 8'h00);
    endtask
    task automatic sc_charge;
        @(posedge sys_clk) sdGrounded <= 1;
        wait_lit(2'b10);
        chk(8'({ctl.refEnable, ctl.chargeEnable}), 8'h03);
        // clearing the allow bit must drop the charge enable
        wr(4'hc, 8'h00);
        tick(1);
        chk(8'(ctl.chargeEnable), 8'h00);
        wr(4'hc, 8'h01);
        @(posedge sys_clk) junctionHot <= 1;
        tick(8);
        chk(8'(ctl.currentReduce), 8'h01);
        @(posedge sys_clk) junctionHot <= 0;
    endtask
    // trip, sit inside the hysteresis band, then release
    task automatic sc_temp(input int trip, input int band, input int ok);
        @(posedge sys_clk) thMv <= trip;
        wait_lit(2'b11);
        chk(8'(ctl.chargeEnable), 8'h00);
        @(posedge sys_clk) thMv <= band;
        tick(12);
        chk_lit(2'b11);
        @(posedge sys_clk) thMv <= ok;
        wait_lit(2'b10);
    endtask
    task automatic sc_done;
        @(posedge sys_clk) currentLow <= 1;
        wait_lit(2'b01);
        chk(8'(n inside {[DEG:DEG + 20]}), 8'h01);
        rd(4'h4);
        chk(d & 8'h07, 8'h07);
    endtask
    task automatic sc_absent;
        wr(4'h4, 8'h1f);
        s0 = sinkCyc;
        c0 = srcCyc;
        @(posedge sys_clk) batPresent <= 0;
        wait_lit(2'b11);
        chk(8'(n inside {[DEG:DEG + 20]}), 8'h01);
        chk(8'((sinkCyc - s0) inside {[DET:DET + 1]}), 8'h01);
        chk(8'((srcCyc - c0) inside {[DET:DET + 1]}), 8'h01);
        tick(2);
        rd(4'h4);
        chk(d & 8'h08, 8'h08);
        chk(8'(irq), 8'h00);
        wr(4'h8, 8'h08);
        tick(2);
        chk(8'(irq), 8'h01);
        wr(4'h4, 8'h08);
        tick(2);
        chk(8'(irq), 8'h00);
    endtask
    // standby, recovery, then the one timer expiry selected by i
    task automatic sc_overtime(input int i);
        @(posedge sys_clk) supplyOk <= 0;
        wait_lit(2'b00);
        @(posedge sys_clk) begin
            supplyOk <= 1;
            batPresent <= 1;
            currentLow <= 0;
        end
        wait_lit(2'b10);
        @(posedge sys_clk) {maxChargeExpired, maxPrechargeExpired} <= 2'(i);
        @(posedge sys_clk) {maxChargeExpired, maxPrechargeExpired} <= 2'b00;
        wait_lit(2'b11);
        rd(4'h0);
        chk(d & 8'h0f, 8'h08);
        rd(4'h4);
        chk(d & 8'h10, 8'h10);
        wr(4'h4, 8'h10);
    endtask

    initial begin
        repeat (16) @(posedge sys_clk);
        rst <= 0;
        sc_reset();
        sc_charge();
        sc_temp(950, 850, 700);
        sc_temp(200, 240, 600);
        sc_done();
        sc_absent();
        sc_overtime(2);
        sc_overtime(1);
        @(posedge sys_clk) sdGrounded <= 0;
        wait_lit(2'b00);
        tick(2);
        chk(8'(ctl.refEnable), 8'h00);
        wrap_up();
    end
endmodule

// *** logic/charger_monitor.sv ***
// charger monitor: temperature window, thermal cutback, absence probe,
// status pins, shutdown and a small register file with interrupt
// assumes comparator results on pins and timer expiries on sys_clk
module charger_monitor
    import charger_monitor_pkg::*;
#(
    parameter longint unsigned MAX_CHARGE_CYCLES =
        `CM_MAX_CHARGE_S * `CM_CLK_HZ
) (
    input  logic                            sys_clk,
    input  logic                            rst,
    input  charger_monitor_pkg::senseIn_t   senseIn,
    input  logic                            maxChargeExpired,
    input  logic                            maxPrechargeExpired,
    input  charger_monitor_pkg::regReq_t    regReq,
    output logic [7:0]                      rdata,
    output logic                            irq,
    output charger_monitor_pkg::chargeCtl_t ctl,
    output charger_monitor_pkg::statusPins_t statusPins
);
    import charger_monitor_pkg::*;

    localparam longint unsigned DEGLITCH_CYCLES =
        MAX_CHARGE_CYCLES / `CM_DEGLITCH_DIV;
    localparam longint unsigned DETECT_CYCLES =
        MAX_CHARGE_CYCLES / `CM_DETECT_DIV;
    localparam logic [`CM_TIMER_W-1:0] DEGLITCH_LOAD =
        `CM_TIMER_W'(DEGLITCH_CYCLES);
    localparam logic [`CM_TIMER_W-1:0] DETECT_LOAD =
        `CM_TIMER_W'(DETECT_CYCLES);

    localparam bit TIME_BASE_OK =
        DETECT_CYCLES >= 64'd1 && DEGLITCH_CYCLES < 64'h1_0000_0000;
    if (!TIME_BASE_OK) begin : badTimeBase
        $error("charge time base gives an unusable interval");
    end

    senseIn_t                 sense;
    logic [`CM_SENSE_W-1:0]   senseBits;
    supState_t                state;
    supState_t                next_state;
    logic                     coldFault;
    logic                     hotFault;
    logic                     next_coldFault;
    logic                     next_hotFault;
    logic                     tempFault;
    logic                     timerStart;
    logic [`CM_TIMER_W-1:0]   timerLoad;
    logic                     timerDone;
    logic                     timeoutHit;
    chargeCtl_t               next_ctl;
    statusPins_t              next_statusPins;
    logic [1:0]               statusOn;
    logic [`CM_EVT_W-1:0]     events;
    logic [`CM_EVT_W-1:0]     next_events;
    logic [`CM_EVT_W-1:0]     evtSet;
    logic [`CM_EVT_W-1:0]     evtClear;
    logic [7:0]               mask;
    logic [7:0]               next_mask;
    logic [7:0]               ctrl;
    logic [7:0]               next_ctrl;
    logic [7:0]               next_rdata;
    logic                     next_irq;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    pin_sync #(
        .WIDTH       (`CM_SENSE_W),
        .RESET_VALUE (`CM_SENSE_RESET)
    ) senseSync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .pinIn   (senseIn),
        .synced  (senseBits)
    );
    assign sense = senseIn_t'(senseBits);

    interval_timer #(
        .WIDTH (`CM_TIMER_W)
    ) probeTimer (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .start     (timerStart),
        .loadValue (timerLoad),
        .done      (timerDone)
    );

    // charging covers the charge, deglitch, sink and source states
    function automatic logic isCharging(input supState_t s);
        return s == ST_CHARGE || s == ST_DEGLITCH ||
               s == ST_SINK || s == ST_SOURCE;
    endfunction

    // temperature window with hysteresis; shutdown clears both
    always_comb begin
        next_coldFault = sense.aboveCold |
                         (coldFault & ~sense.belowColdRelease);
        next_hotFault  = sense.belowHot |
                         (hotFault & ~sense.aboveHotRelease);
        if (sense.shutdownFloat) begin
            next_coldFault = 1'b0;
            next_hotFault  = 1'b0;
        end
    end
    assign tempFault  = coldFault | hotFault;
    assign timeoutHit = maxChargeExpired | maxPrechargeExpired;

    always_comb begin
        next_state = state;
        timerStart = 1'b0;
        timerLoad  = DETECT_LOAD;
        if (sense.shutdownFloat) begin
            next_state = ST_SHUTDOWN;
        end else if (sense.supplyLow) begin
            next_state = ST_STANDBY;
        end else begin
            case (state)
                ST_SHUTDOWN, ST_STANDBY: begin
                    next_state = ST_CHARGE;
                end
                ST_CHARGE: begin
                    if (timeoutHit) begin
                        next_state = ST_OVERTIME;
                    end else if (sense.belowTermination && !tempFault) begin
                        next_state = ST_DEGLITCH;
                        timerStart = 1'b1;
                        timerLoad  = DEGLITCH_LOAD;
                    end
                end
                ST_DEGLITCH: begin
                    if (timeoutHit) begin
                        next_state = ST_OVERTIME;
                    end else if (!sense.belowTermination) begin
                        next_state = ST_CHARGE;
                    end else if (timerDone) begin
                        next_state = ST_SINK;
                        timerStart = 1'b1;
                    end
                end
                ST_SINK: begin
                    if (timerDone) begin
                        // comparator level is the fixed 3 V one
                        if (sense.outBelowPrecharge) begin
                            next_state = ST_SOURCE;
                            timerStart = 1'b1;
                        end else begin
                            next_state = ST_DONE;
                        end
                    end
                end
                ST_SOURCE: begin
                    if (timerDone) begin
                        if (sense.outAboveRecharge) begin
                            next_state = ST_ABSENT;
                            timerStart = 1'b1;
                            timerLoad  = DEGLITCH_LOAD;
                        end else begin
                            next_state = ST_DONE;
                        end
                    end
                end
                ST_DONE: begin
                    if (!sense.outAboveRecharge) begin
                        next_state = ST_CHARGE;
                    end
                end
                ST_ABSENT: begin
                    // re-probe so an inserted pack is noticed
                    if (timerDone) begin
                        next_state = ST_SINK;
                        timerStart = 1'b1;
                    end
                end
                ST_OVERTIME: begin
                    next_state = ST_OVERTIME;
                end
                default: begin
                    next_state = ST_SHUTDOWN;
                end
            endcase
        end
    end

    // outputs follow the next state so they line up with the state register
    always_comb begin
        next_ctl.chargeEnable  = isCharging(next_state) &&
                                 next_state != ST_SINK &&
                                 next_state != ST_SOURCE &&
                                 !(next_coldFault || next_hotFault) &&
                                 ctrl[`CM_CTRL_ALLOW];
        next_ctl.currentReduce = sense.junctionHot &&
                                 !sense.shutdownFloat;
        next_ctl.sinkDetect    = next_state == ST_SINK;
        next_ctl.sourceDetect  = next_state == ST_SOURCE;
        next_ctl.refEnable     = next_state != ST_SHUTDOWN;
        case (next_state)
            ST_SHUTDOWN, ST_STANDBY: statusOn = 2'b00;
            ST_DONE: statusOn = (next_coldFault || next_hotFault) ?
                                2'b11 : 2'b01;
            ST_ABSENT, ST_OVERTIME: statusOn = 2'b11;
            default: statusOn = (next_coldFault || next_hotFault) ?
                                2'b11 : 2'b10;
        endcase
        // pins only ever sink or float, never drive high
        next_statusPins.aOut = 1'b0;
        next_statusPins.aOeN = ~statusOn[1];
        next_statusPins.bOut = 1'b0;
        next_statusPins.bOeN = ~statusOn[0];
    end

    // sticky events, write one to clear, a new event beats the clear
    always_comb begin
        evtSet                   = '0;
        evtSet[`CM_EVT_COLD]     = next_coldFault & ~coldFault;
        evtSet[`CM_EVT_HOT]      = next_hotFault & ~hotFault;
        evtSet[`CM_EVT_DONE]     = next_state == ST_DONE && state != ST_DONE;
        evtSet[`CM_EVT_ABSENT]   = next_state == ST_ABSENT &&
                                   state != ST_ABSENT;
        evtSet[`CM_EVT_OVERTIME] = next_state == ST_OVERTIME &&
                                   state != ST_OVERTIME;
        evtClear = '0;
        next_mask = mask;
        next_ctrl = ctrl;
        if (regReq.write) begin
            case (regReq.addr)
                `CM_OFS_EVENTS: evtClear = regReq.wdata[`CM_EVT_W-1:0];
                `CM_OFS_MASK:   next_mask = regReq.wdata;
                `CM_OFS_CTRL:   next_ctrl = regReq.wdata;
                default:        next_mask = mask;
            endcase
        end
        next_events = (events & ~evtClear) | evtSet;
        next_irq    = |(next_events & next_mask[`CM_EVT_W-1:0]);
        next_rdata  = 8'h00;
        if (regReq.read) begin
            case (regReq.addr)
                `CM_OFS_STATE:  next_rdata = {coldFault, hotFault,
                                              ctl.currentReduce, 1'b0,
                                              state};
                `CM_OFS_EVENTS: next_rdata = {3'h0, events};
                `CM_OFS_MASK:   next_rdata = mask;
                `CM_OFS_CTRL:   next_rdata = ctrl;
                default:        next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state      <= ST_SHUTDOWN;
            coldFault  <= 1'b0;
            hotFault   <= 1'b0;
            ctl        <= '0;
            statusPins <= 4'h5;
            events     <= '0;
            mask       <= `CM_MASK_RESET;
            ctrl       <= `CM_CTRL_RESET;
            rdata      <= 8'h00;
            irq        <= 1'b0;
        end else begin
            state      <= next_state;
            coldFault  <= next_coldFault;
            hotFault   <= next_hotFault;
            ctl        <= next_ctl;
            statusPins <= next_statusPins;
            events     <= next_events;
            mask       <= next_mask;
            ctrl       <= next_ctrl;
            rdata      <= next_rdata;
            irq        <= next_irq;
        end
    end

    sequence live;
        !sense.shutdownFloat && !sense.supplyLow;
    endsequence
    sequence sinkEndLow;
        state == ST_SINK && timerDone && sense.outBelowPrecharge;
    endsequence
    sequence sourceEndHigh;
        state == ST_SOURCE && timerDone && sense.outAboveRecharge;
    endsequence

    thermal_cutback_a: assert property (
        sense.junctionHot && !sense.shutdownFloat |=> ctl.currentReduce)
        else $error("junction hot without current cutback");
    cold_stop_a: assert property (
        sense.aboveCold && !sense.shutdownFloat
        |=> coldFault && !ctl.chargeEnable && !statusPins.bOeN)
        else $error("cold fault did not stop charge");
    cold_hold_a: assert property (
        coldFault && !sense.belowColdRelease && !sense.shutdownFloat
        |=> coldFault)
        else $error("cold fault cleared above release level");
    hot_stop_a: assert property (
        sense.belowHot && !sense.shutdownFloat
        |=> hotFault && !ctl.chargeEnable)
        else $error("hot fault did not stop charge");
    hot_hold_a: assert property (
        hotFault && !sense.aboveHotRelease && !sense.shutdownFloat
        |=> hotFault)
        else $error("hot stop released below release level");
    probe_source_a: assert property (
        sinkEndLow ##0 live |=> state == ST_SOURCE && ctl.sourceDetect
        && !ctl.sinkDetect)
        else $error("low sample did not start the source phase");
    absent_flag_a: assert property (
        sourceEndHigh ##0 live
        |=> state == ST_ABSENT && !statusPins.aOeN && !statusPins.bOeN
        ##1 events[`CM_EVT_ABSENT])
        else $error("swing did not report battery absent");
    charge_status_a: assert property (
        state == ST_CHARGE && !tempFault
        |-> !statusPins.aOeN && statusPins.bOeN)
        else $error("charging shown wrongly on status pins");
    standby_status_a: assert property (
        sense.supplyLow && !sense.shutdownFloat
        |=> state == ST_STANDBY && statusPins.aOeN && statusPins.bOeN)
        else $error("standby did not release both status pins");
    shutdown_release_a: assert property (
        sense.shutdownFloat |=> !ctl.refEnable && statusPins.aOeN &&
        statusPins.bOeN && !ctl.chargeEnable)
        else $error("shutdown left reference or status pins active");
endmodule

// *** logic/charger_monitor_consts.svh ***
// constants of the charger monitor: clock, time base, register map
// assumes inclusion by the package and the design modules only
`ifndef CHARGER_MONITOR_CONSTS_SVH
`define CHARGER_MONITOR_CONSTS_SVH

`define CM_CLK_HZ          64'd10000000
`define CM_MAX_CHARGE_S    64'd10800
`define CM_DEGLITCH_DIV    64'd220
`define CM_DETECT_DIV      64'd54000
`define CM_TIMER_W         32

`define CM_OFS_STATE       4'h0
`define CM_OFS_EVENTS      4'h4
`define CM_OFS_MASK        4'h8
`define CM_OFS_CTRL        4'hc

`define CM_EVT_COLD        0
`define CM_EVT_HOT         1
`define CM_EVT_DONE        2
`define CM_EVT_ABSENT      3
`define CM_EVT_OVERTIME    4
`define CM_EVT_W           5

`define CM_CTRL_ALLOW      0
`define CM_CTRL_RESET      8'h01
`define CM_MASK_RESET      8'h00
`define CM_SENSE_W         10
`define CM_SENSE_RESET     10'h200

`endif

// *** logic/charger_monitor_pkg.sv ***
// types shared by the charger monitor modules
// assumes charger_monitor_consts.svh is on the include path
`include "charger_monitor_consts.svh"

package charger_monitor_pkg;

    // comparator results arriving on pins, msb first
    typedef struct packed {
        logic shutdownFloat;
        logic supplyLow;
        logic aboveCold;
        logic belowColdRelease;
        logic belowHot;
        logic aboveHotRelease;
        logic junctionHot;
        logic belowTermination;
        logic outBelowPrecharge;
        logic outAboveRecharge;
    } senseIn_t;

    // open-collector status pins, enable low while sinking
    typedef struct packed {
        logic aOut;
        logic aOeN;
        logic bOut;
        logic bOeN;
    } statusPins_t;

    typedef struct packed {
        logic chargeEnable;
        logic currentReduce;
        logic sinkDetect;
        logic sourceDetect;
        logic refEnable;
    } chargeCtl_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       write;
        logic       read;
    } regReq_t;

    typedef enum logic [3:0] {
        ST_SHUTDOWN,
        ST_STANDBY,
        ST_CHARGE,
        ST_DEGLITCH,
        ST_SINK,
        ST_SOURCE,
        ST_DONE,
        ST_ABSENT,
        ST_OVERTIME
    } supState_t;

endpackage

// *** logic/interval_timer.sv ***
// down counter giving one pulse a programmed number of cycles after start
// assumes loadValue of at least one; start restarts a running count
module interval_timer #(
    parameter int WIDTH = 32
) (
    input  logic              sys_clk,
    input  logic              rst,
    input  logic              start,
    input  logic [WIDTH-1:0]  loadValue,
    output logic              done
);
    logic [WIDTH-1:0] remaining;
    logic [WIDTH-1:0] next_remaining;
    logic             next_done;

    if (WIDTH < 2) begin : badWidth
        $error("interval_timer needs at least two bits");
    end

    always_comb begin
        next_remaining = remaining;
        next_done      = 1'b0;
        if (start) begin
            next_remaining = loadValue;
        end else if (remaining != '0) begin
            next_remaining = remaining - 1'b1;
            next_done      = (remaining == WIDTH'(1));
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            remaining <= '0;
            done      <= 1'b0;
        end else begin
            remaining <= next_remaining;
            done      <= next_done;
        end
    end
endmodule

// *** logic/pin_sync.sv ***
// three-stage synchroniser for asynchronous comparator pins
// assumes pins may change at any time relative to sys_clk
module pin_sync #(
    parameter int                 WIDTH       = 1,
    parameter logic [WIDTH-1:0]   RESET_VALUE = '0
) (
    input  logic              sys_clk,
    input  logic              rst,
    input  logic [WIDTH-1:0]  pinIn,
    output logic [WIDTH-1:0]  synced
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] next_synced;

    if (WIDTH < 1) begin : badWidth
        $error("pin_sync needs at least one bit");
    end

    // a bit only moves once stages two and three agree
    for (genvar i = 0; i < WIDTH; i++) begin : perBit
        always_comb begin
            next_synced[i] = synced[i];
            if (stage2[i] == stage3[i]) begin
                next_synced[i] = stage3[i];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            stage1 <= RESET_VALUE;
            stage2 <= RESET_VALUE;
            stage3 <= RESET_VALUE;
            synced <= RESET_VALUE;
        end else begin
            stage1 <= pinIn;
            stage2 <= stage1;
            stage3 <= stage2;
            synced <= next_synced;
        end
    end
endmodule
